// [common/mem_cfg.svh]
// Timing counts, register offsets and field positions of the core memory controller
`ifndef MEM_CFG_SVH
`define MEM_CFG_SVH

// ****************************************************************
// Clock and time conversion
// ****************************************************************
`define CLK_MHZ 125
`define NS2CYC(ns) (((ns) * `CLK_MHZ + 500) / 1000)

// ****************************************************************
// Delay-line and gate timing, figures in ns then cycles, then tap numbers
// ****************************************************************
`define TAP_NS 25
`define TAP_CYC `NS2CYC(`TAP_NS)
`define CLK2_NS 30
`define CLK2_CYC `NS2CYC(`CLK2_NS)
`define CLKW_NS 50
`define CLKW_CYC `NS2CYC(`CLKW_NS)
`define INIT_NS 100
`define INIT_CYC `NS2CYC(`INIT_NS)
`define DEL_NS 225
`define DEL_CYC `NS2CYC(`DEL_NS)
`define DELP_NS 125
`define DELP_CYC `NS2CYC(`DELP_NS)
`define TAP_NUM 10
`define TAP_RD 2
`define TAP_SS 4
`define TAP_WR 7

// ****************************************************************
// Mode codes
// ****************************************************************
`define MODE_RD 2'h0
`define MODE_PAUSE 2'h1
`define MODE_WORD 2'h2
`define MODE_BYTE 2'h3

// ****************************************************************
// Register map
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_WORD 8'h08
`define CTRL_STRAP_BIT 0
`define CTRL_RST 1'h0
`define STAT_CIP_BIT 0
`define STAT_PAUSE_BIT 1
`define STAT_DEL_BIT 2
`define STAT_SLAVE_SYNC_BIT 3
`define STAT_XFER_LSB 4

`endif

// [common/mem_pkg.sv]
// Types shared by the core memory controller files
package mem_pkg;
`include "mem_cfg.svh"

  // Transfer types
  typedef enum logic [2:0] {XF_READ, XF_PAUSE, XF_WORD, XF_HIGH, XF_LOW} xfer_t;

  // Cycle gate states
  typedef enum logic [1:0] {ST_IDLE, ST_GATE, ST_BUSY} cyc_state_t;

  // Bus request sampled at cycle start
  typedef struct packed {
    logic [1:0]  mode;
    logic        byteSel;
    logic [15:0] data;
  } bus_req_t;

  // Mode and byte bit decode
  function automatic xfer_t decode(logic [1:0] m, logic a0);
    xfer_t x;
    x = XF_READ;
    case (m)
      `MODE_RD:    x = XF_READ;
      `MODE_PAUSE: x = XF_PAUSE;
      `MODE_WORD:  x = XF_WORD;
      `MODE_BYTE:  x = a0 ? XF_HIGH : XF_LOW;
      default:     x = XF_READ;
    endcase
    return x;
  endfunction
endpackage

// [verilog/sync2.sv]
// Two-stage synchroniser for level inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,  // System clock
  input  wire logic         nrst, // Sync reset, low
  input  wire logic [W-1:0] d,    // Asynchronous levels
  output logic      [W-1:0] q     // Synchronised levels
);
  logic [W-1:0] meta_r;

  // First stage feeds second stage only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [verilog/tap_chain.sv]
// Counter-based delay line with evenly spaced taps
`timescale 1ns/100ps
module tap_chain #(
  parameter int TAPS    = 10,
  parameter int TAP_CYC = 3,
  parameter int CW      = 6
) (
  input  wire logic            clk,  // System clock
  input  wire logic            nrst, // Sync reset, low
  input  wire logic            run,  // Timing start flag
  output logic      [CW-1:0]   cnt,  // Cycles since activation
  output logic      [TAPS-1:0] taps  // Tap i after i spacings
);
  logic [CW-1:0] cnt_nxt;

  // Count while active
  always_comb begin
    cnt_nxt = run ? cnt + CW'(1) : '0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= '0;
    end else begin
      cnt <= cnt_nxt;
    end
  end

  // Tap outputs
  for (genvar i = 0; i < TAPS; i++) begin : g_tap
    assign taps[i] = run && (cnt >= CW'(i * TAP_CYC));
  end
endmodule

// [verilog/mem_cycle_ctrl.sv]
// Core memory mode decode, cycle start gate and timing base
//
// Behaviour
// R01 - Transfer type comes from both mode bits and address bit zero.
// R02 - Mode 00 reads word to master, then restores it.
// R03 - Mode 01 returns data, sets pause flag, no restore write.
// R04 - Mode 10 writes the full word.
// R05 - Mode 11 writes high byte if bit zero set, else low byte.
// R06 - Master follows read-with-pause with a write to same address.
// R07 - With pause set, a write skips the read phase, shorter cycle.
// R08 - Read-only strap forces mode bits to zero.
// R09 - Decoder makes byte loads, clears, strobes, data enable, pause, slave sync.
// R10 - Init clears cycle flag after 100 ns, and other flags.
// R11 - Start needs address match, idle, slave sync idle, master sync.
// R12 - First clock pulse at start, second 30 ns later.
// R13 - Delayed start sets cycle flag, blocking start; pulses about 50 ns.
// R14 - Timing base gives taps 25 ns apart.
// R15 - Master drives address, mode and data before master sync.
// R16 - Processor asserts init at power-up.
// R17 - Byte write without pause reads both, restores other byte.
// R18 - Data register cleared per byte at operation start.
// R19 - Timing start flag holds about 225 ns, cleared by tap or init.
// R20 - Delays are cycle counts rounded to nearest cycle.
// R21 - Master sync and device select are synchronised.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`include "mem_cfg.svh"
module mem_cycle_ctrl #(
  parameter int AW = 10
) (
  input  wire logic              clk,        // System clock
  input  wire logic              nrst,       // Sync reset, low
  input  wire logic              busInit,    // Bus initialise
  input  wire logic              masterSync, // Master sync
  input  wire logic              devSelect,  // Device address match
  input  wire mem_pkg::bus_req_t busReq,     // Mode, byte bit, data
  input  wire logic [AW-1:0]     addr,       // Word address
  output logic      [15:0]       dataOut,    // Read data to bus
  output logic                   dataOutEn,  // Read data enable
  output logic                   slaveSync,  // Slave sync
  output logic                   clkOne,     // First clock pulse
  output logic                   clkTwo,     // Second clock pulse
  input  wire logic              psel,       // APB select
  input  wire logic              penable,    // APB enable
  input  wire logic              pwrite,     // APB direction
  input  wire logic [7:0]        paddr,      // APB address
  input  wire logic [31:0]       pwdata,     // APB write data
  output logic      [31:0]       prdata,     // APB read data
  output logic                   pready,     // APB ready
  output logic                   pslverr     // APB error
);
  import mem_pkg::*;

  localparam int CW = 6;
  localparam int A_CLK2 = `CLK2_CYC;
  localparam int A_INIT = `INIT_CYC;
  localparam logic [3:0] C_CLK2 = 4'(`CLK2_CYC);
  localparam logic [3:0] C_CLKE = 4'(`CLK2_CYC + `CLKW_CYC);
  localparam logic [3:0] C_CLKW = 4'(`CLKW_CYC);
  localparam logic [3:0] C_INIT = 4'(A_INIT - 1);
  localparam logic [CW-1:0] C_RD  = CW'(`TAP_RD * `TAP_CYC);
  localparam logic [CW-1:0] C_SS  = CW'(`TAP_SS * `TAP_CYC);
  localparam logic [CW-1:0] C_WR  = CW'(`TAP_WR * `TAP_CYC);
  localparam logic [CW-1:0] C_DEL = CW'(`DEL_CYC - 1);
  localparam logic [CW-1:0] C_DLP = CW'(`DELP_CYC - 1);

  // ****************************************************************
  // Storage and input synchronisers
  // ****************************************************************
  logic [15:0]   mem [0:2**AW-1];
  logic [1:0]    syncOut;
  logic          mSync;
  logic          dSel;
  logic [CW-1:0] cnt;
  logic [`TAP_NUM-1:0] taps;

  // Master sync and select synchronised
  sync2 #(.W(2)) uSync ( // R21
    .clk  (clk),
    .nrst (nrst),
    .d    ({masterSync, devSelect}),
    .q    (syncOut)
  );
  assign mSync = syncOut[1];
  assign dSel  = syncOut[0];

  // ****************************************************************
  // Cycle start gate
  // ****************************************************************
  cyc_state_t    state_r, state_nxt;
  logic [3:0]    gateCnt_r, gateCnt_nxt;
  logic [3:0]    initCnt_r, initCnt_nxt;
  logic          cip_r, cip_nxt;
  logic          clkOne_nxt, clkTwo_nxt;
  xfer_t         xfer_r, xfer_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [15:0]   din_r, din_nxt;
  logic          strap_r, strap_nxt;
  logic [1:0]    effMode;
  logic          startCond;
  logic          delStart;
  logic          del_r;
  logic          slaveSync_r;

  // Strap forces mode bits to zero
  assign effMode = strap_r ? `MODE_RD : busReq.mode; // R08
  // All four conditions and the idle gate state together
  assign startCond = dSel && !cip_r && !slaveSync_r && mSync && state_r == ST_IDLE; // R11

  // Gate next state
  always_comb begin
    state_nxt   = state_r;
    gateCnt_nxt = gateCnt_r;
    initCnt_nxt = busInit ? initCnt_r + 4'h1 : 4'h0;
    cip_nxt     = cip_r;
    clkOne_nxt  = 1'b0;
    clkTwo_nxt  = 1'b0;
    xfer_nxt    = xfer_r;
    addr_nxt    = addr_r;
    din_nxt     = din_r;
    delStart    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (startCond) begin
          xfer_nxt    = decode(effMode, busReq.byteSel); // R01
          addr_nxt    = addr;
          din_nxt     = busReq.data;
          gateCnt_nxt = 4'h0;
          clkOne_nxt  = 1'b1; // R12
          state_nxt   = ST_GATE;
        end
      end
      ST_GATE: begin
        gateCnt_nxt = gateCnt_r + 4'h1;
        clkOne_nxt  = gateCnt_nxt < C_CLKW; // R13
        clkTwo_nxt  = gateCnt_nxt >= C_CLK2 && gateCnt_nxt < C_CLKE; // R12
        if (gateCnt_nxt == C_CLK2) begin
          cip_nxt  = 1'b1; // R13
          delStart = 1'b1;
        end
        if (gateCnt_nxt == C_CLKE) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (!del_r && !slaveSync_r && !mSync) begin
          cip_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (busInit) begin
      xfer_nxt   = XF_READ; // R10
      clkOne_nxt = 1'b0;
      clkTwo_nxt = 1'b0;
      delStart   = 1'b0;
      state_nxt  = ST_IDLE;
      if (initCnt_r == C_INIT) begin
        cip_nxt = 1'b0; // R10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r   <= ST_IDLE;
      gateCnt_r <= 4'h0;
      initCnt_r <= 4'h0;
      cip_r     <= 1'b0;
      clkOne    <= 1'b0;
      clkTwo    <= 1'b0;
      xfer_r    <= XF_READ;
      addr_r    <= '0;
      din_r     <= 16'h0000;
    end else begin
      state_r   <= state_nxt;
      gateCnt_r <= gateCnt_nxt;
      initCnt_r <= initCnt_nxt;
      cip_r     <= cip_nxt;
      clkOne    <= clkOne_nxt;
      clkTwo    <= clkTwo_nxt;
      xfer_r    <= xfer_nxt;
      addr_r    <= addr_nxt;
      din_r     <= din_nxt;
    end
  end

  // ****************************************************************
  // Timing base and byte masking
  // ****************************************************************
  tap_chain #(.TAPS(`TAP_NUM), .TAP_CYC(`TAP_CYC), .CW(CW)) uTaps ( // R14
    .clk  (clk),
    .nrst (nrst),
    .run  (del_r),
    .cnt  (cnt),
    .taps (taps)
  );

  logic        del_nxt, pause_r, pause_nxt, slaveSync_nxt;
  logic [15:0] word_r, word_nxt, dataOut_nxt;
  logic        dataOutEn_nxt;
  logic        isRead, isWrite, pw, rdAt, loadAt, memWe, delClear;
  logic [1:0]  clr, strobe, load;
  logic [15:0] memRd;

  assign memRd   = mem[addr_r];
  assign isRead  = xfer_r == XF_READ || xfer_r == XF_PAUSE;
  assign isWrite = !isRead;
  // Write after pause skips read phase
  assign pw      = pause_r && isWrite; // R07
  assign rdAt    = del_r && !pw && taps[`TAP_RD] && cnt == C_RD;
  assign loadAt  = del_r && cnt == (pw ? '0 : C_RD);
  // Restore or write, never during read-with-pause
  assign memWe   = del_r && xfer_r != XF_PAUSE && cnt == (pw ? C_RD : C_WR); // R02 R03 R04
  // Tap-derived clear of timing flag
  assign delClear = del_r && cnt == (pw ? C_DLP : C_DEL); // R19 R20

  // Per-byte clears, strobes and loads
  always_comb begin
    clr[0]    = del_r && cnt == '0 && !pw; // R18
    clr[1]    = clr[0]; // R18
    strobe[0] = rdAt && xfer_r != XF_WORD && xfer_r != XF_LOW; // R09 R17
    strobe[1] = rdAt && xfer_r != XF_WORD && xfer_r != XF_HIGH; // R09 R17
    load[0]   = loadAt && (xfer_r == XF_WORD || xfer_r == XF_LOW); // R05 R09
    load[1]   = loadAt && (xfer_r == XF_WORD || xfer_r == XF_HIGH); // R05 R09
  end

  // Timing flags and data register
  always_comb begin
    word_nxt      = word_r;
    del_nxt       = del_r;
    pause_nxt     = pause_r;
    slaveSync_nxt = slaveSync_r;
    dataOut_nxt   = dataOut;
    dataOutEn_nxt = dataOutEn;
    for (int b = 0; b < 2; b++) begin
      if (clr[b]) begin
        word_nxt[b*8 +: 8] = 8'h00;
      end else if (strobe[b]) begin
        word_nxt[b*8 +: 8] = memRd[b*8 +: 8];
      end else if (load[b]) begin
        word_nxt[b*8 +: 8] = din_r[b*8 +: 8];
      end
    end
    if (delStart) begin
      del_nxt = 1'b1; // R13
    end else if (delClear) begin
      del_nxt = 1'b0; // R19
    end
    if (rdAt && isRead) begin
      dataOut_nxt   = memRd; // R02 R03
      dataOutEn_nxt = 1'b1; // R09
    end
    if (rdAt && xfer_r == XF_PAUSE) begin
      pause_nxt = 1'b1; // R03
    end else if (delClear && pw) begin // Held to cycle end so pw stays stable
      pause_nxt = 1'b0; // R07
    end
    if (del_r && cnt == (pw ? C_RD : C_SS)) begin
      slaveSync_nxt = 1'b1; // R09
    end else if (!mSync && slaveSync_r) begin
      slaveSync_nxt = 1'b0;
      dataOutEn_nxt = 1'b0;
    end
    if (busInit) begin
      del_nxt       = 1'b0; // R10
      pause_nxt     = 1'b0; // R10
      slaveSync_nxt = 1'b0;
      dataOutEn_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      word_r      <= 16'h0000;
      del_r       <= 1'b0;
      pause_r     <= 1'b0;
      slaveSync_r <= 1'b0;
      dataOut     <= 16'h0000;
      dataOutEn   <= 1'b0;
    end else begin
      word_r      <= word_nxt;
      del_r       <= del_nxt;
      pause_r     <= pause_nxt;
      slaveSync_r <= slaveSync_nxt;
      dataOut     <= dataOut_nxt;
      dataOutEn   <= dataOutEn_nxt;
    end
  end
  assign slaveSync = slaveSync_r;

  // Core array write, whole word from the data register
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[addr_r] <= word_r;
    end
  end

  // ****************************************************************
  // APB register slave
  // ****************************************************************
  logic        pready_nxt, pslverr_nxt, acc, commit;
  logic [31:0] prdata_nxt;

  assign acc    = psel && penable && !pready;
  assign commit = psel && penable && pready && pwrite;

  // Read mux and one wait state
  always_comb begin
    pready_nxt  = acc;
    prdata_nxt  = prdata;
    pslverr_nxt = 1'b0;
    strap_nxt   = strap_r;
    if (acc) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `OFS_CTRL: prdata_nxt[`CTRL_STRAP_BIT] = strap_r;
        `OFS_STAT: begin
          prdata_nxt[`STAT_CIP_BIT]   = cip_r;
          prdata_nxt[`STAT_PAUSE_BIT] = pause_r;
          prdata_nxt[`STAT_DEL_BIT]   = del_r;
          prdata_nxt[`STAT_SLAVE_SYNC_BIT]  = slaveSync_r;
          prdata_nxt[`STAT_XFER_LSB +: 3] = xfer_r;
        end
        `OFS_WORD: prdata_nxt[15:0] = word_r;
        default:   pslverr_nxt = 1'b1;
      endcase
    end
    if (commit && paddr == `OFS_CTRL) begin
      strap_nxt = pwdata[`CTRL_STRAP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_r <= `CTRL_RST;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
      pready  <= pready_nxt;
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_clk_one: assert property (startCond && !busInit |=> clkOne && state_r == ST_GATE) // R11
    else $error("start did not raise first clock");
  a_clk_two_delay: assert property ($rose(clkOne) |-> ##A_CLK2 $rose(clkTwo)) // R12
    else $error("second clock not at its delay");
  a_cip_blocks: assert property ($rose(cip_r) |-> ##[1:8] !clkOne && !clkTwo) // R13
    else $error("clock pulses not ended by cycle flag");
  a_strap_read: assert property (strap_r && startCond && !busInit |=> xfer_r == XF_READ) // R08
    else $error("strap did not force word read");
  a_pause_set: assert property (rdAt && xfer_r == XF_PAUSE && !busInit |=> pause_r) // R03
    else $error("pause flag not set on read-with-pause");
  a_no_restore: assert property (xfer_r == XF_PAUSE && del_r |=> memRd == $past(memRd)) // R03
    else $error("restore during read-with-pause");
  a_init_flags: assert property (busInit |=> !pause_r && !del_r && !slaveSync_r) // R10
    else $error("init left a flag set");
  a_init_cip: assert property (busInit [*8] ##1 busInit [*5] |=> !cip_r) // R10
    else $error("cycle flag not cleared after init delay");
  a_byte_hi: assert property (memWe && xfer_r == XF_HIGH |-> word_r[15:8] == din_r[15:8]) // R05
    else $error("high byte not from upper data lines");
  a_del_width: assert property ($rose(del_r) && !busInit |-> del_r [*8]) // R19
    else $error("timing flag ended early");
  a_dout_read: assert property ($rose(dataOutEn) |-> isRead && $past(rdAt)) // R02
    else $error("data driven outside a read");
  a_short_write: assert property (pw && $rose(del_r) |-> ##[10:20] !del_r) // R07
    else $error("pause write not shortened");
endmodule

// [verif/bus_master_model.sv]
// Bus master model that runs memory transfers on the shared system bus
`timescale 1ns/100ps
module bus_master_model #(
  parameter int AW = 10
) (
  input  wire logic              clk,        // System clock
  input  wire logic              slaveSync,  // Slave sync from memory
  input  wire logic      [15:0]  dataOut,    // Read data
  input  wire logic              dataOutEn,  // Read data enable
  output mem_pkg::bus_req_t      busReq,     // Mode, byte bit, data
  output logic           [AW-1:0] addr,      // Word address
  output logic                   masterSync, // Master sync
  output logic                   devSelect   // Address match
);
  import mem_pkg::*;

  // Bus idle at start
  initial begin
    busReq = '0;
    addr = '0;
    masterSync = 1'b0;
    devSelect = 1'b0;
  end

  // One full transfer; lat counts edges from master sync to slave sync
  task automatic xfer(input logic [1:0] m, input logic bsel, input logic [AW-1:0] a, input logic [15:0] d,
                      input logic sel, output logic [15:0] rd, output logic en, output int lat, output logic ok);
    ok = 1'b0;
    rd = '0;
    en = 1'b0;
    lat = 0;
    busReq <= {m, bsel, d};
    addr <= a;
    devSelect <= sel;
    @(posedge clk);
    masterSync <= 1'b1;
    while (!ok && lat < 100) begin
      @(posedge clk);
      lat++;
      if (slaveSync === 1'b1) begin
        ok = 1'b1;
        rd = dataOut;
        en = dataOutEn;
      end
    end
    masterSync <= 1'b0;
    for (int i = 0; i < 100 && slaveSync !== 1'b0; i++) @(posedge clk);
    // Released data and address lines show inverted values, not the last ones
    busReq.data <= ~d;
    addr <= ~a;
    devSelect <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the core memory cycle controller
`timescale 1ns/100ps
`include "mem_cfg.svh"
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import mem_pkg::*;
  logic        clk, nrst, busInit, masterSync, devSelect, psel, penable, pwrite, pready, pslverr;
  logic        dataOutEn, slaveSync, clkOne, clkTwo, p1, p2, en, ok, err;
  logic [15:0] dataOut, rd;
  logic [9:0]  addr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r32;
  bus_req_t    busReq;
  int          errTotal, cmpCount, cyc, t1, t2, w1, w2, n1, n0, lat, latN;

  mem_cycle_ctrl #(.AW(10)) u_mem_cycle_ctrl (.clk(clk), .nrst(nrst), .busInit(busInit),
    .masterSync(masterSync), .devSelect(devSelect), .busReq(busReq), .addr(addr), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .slaveSync(slaveSync), .clkOne(clkOne), .clkTwo(clkTwo), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bus_master_model #(.AW(10)) u_bus_master_model (.clk(clk), .slaveSync(slaveSync), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .busReq(busReq), .addr(addr), .masterSync(masterSync), .devSelect(devSelect));

  // ****************************************************************
  // Clock, pulse monitor and timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Records rise times and widths of both clock pulses
  always @(posedge clk) begin
    cyc++;
    if (clkOne === 1'b1 && p1 !== 1'b1) begin
      t1 = cyc;
      n1++;
      w1 = 0;
    end
    if (clkTwo === 1'b1 && p2 !== 1'b1) begin
      t2 = cyc;
      w2 = 0;
    end
    if (clkOne === 1'b1) w1++;
    if (clkTwo === 1'b1) w2++;
    p1 = clkOne;
    p2 = clkTwo;
    if (cyc > 20000) begin
      errTotal++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One register access: setup, access until ready, release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for ready however long it takes; only the bench timeout ends it
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic mem(input logic [1:0] m, input logic b, input logic [9:0] a, input logic [15:0] d);
    u_bus_master_model.xfer(m, b, a, d, 1'b1, rd, en, lat, ok);
    `CHK("slave sync", 1'b1, ok)
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    busInit = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {errTotal, cmpCount, cyc, n1} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (14) @(posedge clk);
    busInit <= 1'b0;
    @(posedge clk);
    apb(1'b0, `OFS_CTRL, 32'h0, r32, err);
    `CHK("ctrl reset", 32'h0, r32)
    apb(1'b0, `OFS_STAT, 32'h0, r32, err);
    `CHK("stat reset", 32'h0, r32)
    apb(1'b0, 8'h0C, 32'h0, r32, err);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, r32)
    // Word write, read and restore, pulse timing
    mem(`MODE_WORD, 1'b0, 10'h005, 16'h1234);
    `CHK("write no data enable", 1'b0, en)
    latN = lat;
    `CHK("clk2 delay", 1'b1, t2 - t1 == `CLK2_CYC)
    `CHK("clk1 width", 1'b1, w1 == `CLKW_CYC)
    `CHK("clk2 width", 1'b1, w2 == `CLKW_CYC)
    mem(`MODE_RD, 1'b1, 10'h005, 16'hFFFF);
    `CHK("read data", 16'h1234, rd)
    `CHK("read enable", 1'b1, en)
    mem(`MODE_RD, 1'b0, 10'h005, 16'h0000);
    `CHK("restored", 16'h1234, rd)
    apb(1'b0, `OFS_STAT, 32'h0, r32, err);
    `CHK("type read", 3'h0, r32[6:4])
    // Byte writes keep the other byte
    mem(`MODE_BYTE, 1'b1, 10'h005, 16'hABEE);
    mem(`MODE_BYTE, 1'b0, 10'h005, 16'hEECD);
    mem(`MODE_RD, 1'b0, 10'h005, 16'h0000);
    `CHK("byte merge", 16'hABCD, rd)
    mem(`MODE_WORD, 1'b1, 10'h006, 16'h0F0F);
    // Read with pause then shortened writes
    mem(`MODE_PAUSE, 1'b0, 10'h006, 16'h0000);
    `CHK("pause read", 16'h0F0F, rd)
    apb(1'b0, `OFS_STAT, 32'h0, r32, err);
    `CHK("pause flag", 1'b1, r32[`STAT_PAUSE_BIT])
    `CHK("type pause", 3'h1, r32[6:4])
    mem(`MODE_WORD, 1'b0, 10'h006, 16'h5A5A);
    `CHK("short write", 1'b1, lat < latN)
    mem(`MODE_PAUSE, 1'b0, 10'h006, 16'h0000);
    `CHK("pause read 2", 16'h5A5A, rd)
    mem(`MODE_BYTE, 1'b0, 10'h006, 16'hEE11);
    `CHK("short byte write", 1'b1, lat < latN)
    mem(`MODE_RD, 1'b0, 10'h006, 16'h0000);
    `CHK("pause byte merge", 16'h5A11, rd)
    // Initialise in mid pause clears flags
    mem(`MODE_PAUSE, 1'b0, 10'h006, 16'h0000);
    busInit <= 1'b1;
    repeat (14) @(posedge clk);
    busInit <= 1'b0;
    @(posedge clk);
    apb(1'b0, `OFS_STAT, 32'h0, r32, err);
    `CHK("init flags", 4'h0, r32[3:0])
    mem(`MODE_WORD, 1'b0, 10'h006, 16'hC3C3);
    `CHK("full write", 1'b1, lat == latN)
    // Read-only strap turns writes into reads
    apb(1'b1, `OFS_CTRL, 32'h1, r32, err);
    mem(`MODE_WORD, 1'b0, 10'h006, 16'h0000);
    `CHK("strap read", 16'hC3C3, rd)
    `CHK("strap enable", 1'b1, en)
    apb(1'b1, `OFS_CTRL, 32'h0, r32, err);
    mem(`MODE_RD, 1'b0, 10'h006, 16'h0000);
    `CHK("strap kept", 16'hC3C3, rd)
    // Initialise during a running cycle, then the held request restarts
    fork
      u_bus_master_model.xfer(`MODE_RD, 1'b0, 10'h006, 16'h0000, 1'b1, rd, en, lat, ok);
      begin
        repeat (16) @(posedge clk);
        busInit <= 1'b1;
        repeat (14) @(posedge clk);
        apb(1'b0, `OFS_STAT, 32'h0, r32, err);
        busInit <= 1'b0;
      end
    join
    `CHK("init cycle flag", 1'b0, r32[`STAT_CIP_BIT])
    `CHK("restart sync", 1'b1, ok)
    `CHK("restart read", 16'hC3C3, rd)
    // No start without address match
    n0 = n1;
    u_bus_master_model.xfer(`MODE_RD, 1'b0, 10'h006, 16'h0000, 1'b0, rd, en, lat, ok);
    `CHK("no select", 1'b0, ok)
    `CHK("no pulse", 1'b1, n1 == n0)
    report_and_stop();
  end
endmodule
